// ===== src/rdc_defs.svh
/*
 Register map constants of the radio debug and frame configuration bank.
 Assumes inclusion by bare name from files under src/.
*/
`ifndef RDC_DEFS_SVH
`define RDC_DEFS_SVH

// Register indices; byte address is four times the index
`define RDC_IDX_FRAME_HI      20'h0df00
`define RDC_IDX_FRAME_LO      20'h0df01
`define RDC_IDX_PKT_LEN       20'h0df02
`define RDC_IDX_PIN_A         20'h0df2f
`define RDC_IDX_PIN_B         20'h0df30
`define RDC_IDX_PIN_C         20'h0df31

`define RDC_ADDR_W            22
`define RDC_ADDR_FRAME_HI     22'h037c00
`define RDC_ADDR_FRAME_LO     22'h037c04
`define RDC_ADDR_PKT_LEN      22'h037c08
`define RDC_ADDR_PIN_A        22'h037cbc
`define RDC_ADDR_PIN_B        22'h037cc0
`define RDC_ADDR_PIN_C        22'h037cc4

`define RDC_RST_FRAME_HI      8'hd3
`define RDC_RST_FRAME_LO      8'h91
`define RDC_RST_PKT_LEN       8'hff
`define RDC_RST_SEL           6'h00
`define RDC_RST_INV           1'h0
`define RDC_RST_DRIVE         1'h0

`define RDC_BIT_DRIVE         7
`define RDC_BIT_INV           6
`define RDC_SEL_MSB           5
`define RDC_SEL_W             6

`define RDC_RESP_OKAY         2'h0
`define RDC_RESP_SLVERR       2'h2

`endif

// ===== src/rdc_pkg.sv
/*
 Types shared by the radio debug and frame configuration bank.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rdc_pkg;

    typedef struct packed {
        logic       invert;
        logic [5:0] select;
    } rdc_pin_cfg_s;

    typedef struct packed {
        logic [15:0] frame_word;
        logic [7:0]  packet_length;
    } rdc_frame_cfg_s;

endpackage

// ===== src/rdc_debug_pin.sv
/*
 One debug output pin: picks one internal radio signal and sets its polarity.
 Assumes the radio signal vector is synchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none

module rdc_debug_pin #(
    parameter int NUM_SIG = 64
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [NUM_SIG-1:0] radio_signals,
    input  wire rdc_pkg::rdc_pin_cfg_s cfg,
    output var  logic               pin_q
);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= radio_signals[cfg.select] ^ cfg.invert;
        end
    end

endmodule

`default_nettype wire

// ===== src/rdc_regs.sv
/*
 AXI4-Lite register bank for debug pin routing, drive strength, frame-start
 word and packet length limit, with the pin routing muxes.
 Assumes a single aclk domain and a master that follows AXI4-Lite handshakes.
*/
// The implementer's own choice: the AXI4-Lite slave port.
// Contract
// - Bit 6 of each pin register inverts its routed signal; 1 is active low.
// - Pin A register bits 5:0 select port_one_pin_seven signal, reset zero.
// - Pin B register bits 5:0 select port_one_pin_six signal, reset zero.
// - Pin C register bits 5:0 select port_one_pin_five signal, reset zero.
// - Pin B register bit 7 sets drive strength; 0 minimum, 1 maximum.
// - High frame register gives upper frame-start byte, reset d3.
// - Low frame register gives lower frame-start byte, reset 91.
// - In fixed-length mode the length register is the exact packet length.
// - In variable-length mode the length register is the largest allowed length.
`include "rdc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module rdc_regs #(
    parameter int NUM_SIG = 64
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [`RDC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output var  logic                   s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output var  logic                   s_axi_wready,
    output var  logic [1:0]             s_axi_bresp,
    output var  logic                   s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`RDC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output var  logic                   s_axi_arready,
    output var  logic [31:0]            s_axi_rdata,
    output var  logic [1:0]             s_axi_rresp,
    output var  logic                   s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [NUM_SIG-1:0]     radio_signals,
    input  wire logic                   fixed_length_mode,
    input  wire logic                   rx_length_valid,
    input  wire logic [7:0]             rx_length,
    output var  rdc_pkg::rdc_frame_cfg_s frame_cfg_q,
    output var  logic                   rx_length_ok_q,
    output var  logic                   pin_drive_strength_q,
    output var  logic                   port_one_pin_seven_q,
    output var  logic                   port_one_pin_six_q,
    output var  logic                   port_one_pin_five_q
);

    rdc_pkg::rdc_pin_cfg_s pin_a_cfg_q;
    rdc_pkg::rdc_pin_cfg_s pin_b_cfg_q;
    rdc_pkg::rdc_pin_cfg_s pin_c_cfg_q;

    logic                   aw_held_q;
    logic                   w_held_q;
    logic [`RDC_ADDR_W-1:0] awaddr_q;
    logic [7:0]             wbyte_q;
    logic                   wlane_q;
    logic                   do_write;
    logic                   wr_hit;
    logic                   rd_hit;
    logic [7:0]             rd_byte;

    // Address and data may arrive in either order; each is held until both are in
    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

    always_comb begin
        wr_hit = 1'b1;
        unique case (awaddr_q)
            `RDC_ADDR_FRAME_HI, `RDC_ADDR_FRAME_LO, `RDC_ADDR_PKT_LEN,
            `RDC_ADDR_PIN_A, `RDC_ADDR_PIN_B, `RDC_ADDR_PIN_C: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            awaddr_q      <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (do_write) begin
                aw_held_q     <= 1'b0;
            end else begin
                s_axi_awready <= !aw_held_q;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q     <= 1'b0;
            wbyte_q      <= 8'h00;
            wlane_q      <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q     <= 1'b1;
                wbyte_q      <= s_axi_wdata[7:0];
                wlane_q      <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (do_write) begin
                w_held_q     <= 1'b0;
            end else begin
                s_axi_wready <= !w_held_q;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RDC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `RDC_RESP_OKAY : `RDC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Only byte lane 0 carries register data; other lanes are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_cfg_q.frame_word[15:8] <= `RDC_RST_FRAME_HI;
            frame_cfg_q.frame_word[7:0]  <= `RDC_RST_FRAME_LO;
            frame_cfg_q.packet_length    <= `RDC_RST_PKT_LEN;
        end else if (do_write && wlane_q) begin
            if (awaddr_q == `RDC_ADDR_FRAME_HI) begin
                frame_cfg_q.frame_word[15:8] <= wbyte_q;
            end
            if (awaddr_q == `RDC_ADDR_FRAME_LO) begin
                frame_cfg_q.frame_word[7:0] <= wbyte_q;
            end
            if (awaddr_q == `RDC_ADDR_PKT_LEN) begin
                frame_cfg_q.packet_length <= wbyte_q;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_a_cfg_q          <= {`RDC_RST_INV, `RDC_RST_SEL};
            pin_b_cfg_q          <= {`RDC_RST_INV, `RDC_RST_SEL};
            pin_c_cfg_q          <= {`RDC_RST_INV, `RDC_RST_SEL};
            pin_drive_strength_q <= `RDC_RST_DRIVE;
        end else if (do_write && wlane_q) begin
            if (awaddr_q == `RDC_ADDR_PIN_A) begin
                pin_a_cfg_q <= wbyte_q[`RDC_BIT_INV:0];
            end
            if (awaddr_q == `RDC_ADDR_PIN_B) begin
                pin_b_cfg_q          <= wbyte_q[`RDC_BIT_INV:0];
                pin_drive_strength_q <= wbyte_q[`RDC_BIT_DRIVE];
            end
            if (awaddr_q == `RDC_ADDR_PIN_C) begin
                pin_c_cfg_q <= wbyte_q[`RDC_BIT_INV:0];
            end
        end
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        unique case (s_axi_araddr)
            `RDC_ADDR_FRAME_HI: rd_byte = frame_cfg_q.frame_word[15:8];
            `RDC_ADDR_FRAME_LO: rd_byte = frame_cfg_q.frame_word[7:0];
            `RDC_ADDR_PKT_LEN:  rd_byte = frame_cfg_q.packet_length;
            `RDC_ADDR_PIN_A:    rd_byte = {1'b0, pin_a_cfg_q};
            `RDC_ADDR_PIN_B:    rd_byte = {pin_drive_strength_q, pin_b_cfg_q};
            `RDC_ADDR_PIN_C:    rd_byte = {1'b0, pin_c_cfg_q};
            default:            rd_hit  = 1'b0;
        endcase
    end

    // One read in flight; arready drops while the answer waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RDC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h00_0000, rd_byte};
            s_axi_rresp   <= rd_hit ? `RDC_RESP_OKAY : `RDC_RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Length check is registered so the verdict lags rx_length_valid by one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_length_ok_q <= 1'b0;
        end else if (rx_length_valid) begin
            if (fixed_length_mode) begin
                rx_length_ok_q <= (rx_length == frame_cfg_q.packet_length);
            end else begin
                rx_length_ok_q <= (rx_length <= frame_cfg_q.packet_length);
            end
        end
    end

    rdc_debug_pin #(.NUM_SIG(NUM_SIG)) u_pin_a (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .radio_signals (radio_signals),
        .cfg           (pin_a_cfg_q),
        .pin_q         (port_one_pin_seven_q)
    );

    rdc_debug_pin #(.NUM_SIG(NUM_SIG)) u_pin_b (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .radio_signals (radio_signals),
        .cfg           (pin_b_cfg_q),
        .pin_q         (port_one_pin_six_q)
    );

    rdc_debug_pin #(.NUM_SIG(NUM_SIG)) u_pin_c (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .radio_signals (radio_signals),
        .cfg           (pin_c_cfg_q),
        .pin_q         (port_one_pin_five_q)
    );

endmodule

`default_nettype wire

// ===== verif/rdc_regs_chk.sv
/* Port checker for rdc_regs: reset values, config updates, length verdicts.
   Assumes one aclk domain; bound to every rdc_regs instance. */
`timescale 1ns/1ps
`default_nettype none
module rdc_regs_chk (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_rvalid,
    input wire logic [31:0]             s_axi_rdata,
    input wire logic                    fixed_length_mode,
    input wire logic                    rx_length_valid,
    input wire logic [7:0]              rx_length,
    input wire rdc_pkg::rdc_frame_cfg_s frame_cfg_q,
    input wire logic                    rx_length_ok_q,
    input wire logic                    pin_drive_strength_q,
    input wire logic                    port_one_pin_seven_q,
    input wire logic                    port_one_pin_six_q,
    input wire logic                    port_one_pin_five_q
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rst_cfg_a: assert property (!$past(aresetn) |->
        frame_cfg_q == 24'hd391ff && !pin_drive_strength_q) else $error("config not at reset");
    rst_pins_a: assert property (!$past(aresetn) |->
        {port_one_pin_seven_q, port_one_pin_six_q, port_one_pin_five_q} == 3'h0)
        else $error("debug pins not low after reset");
    fixed_len_a: assert property (rx_length_valid && fixed_length_mode |=>
        rx_length_ok_q == ($past(rx_length) == $past(frame_cfg_q.packet_length)))
        else $error("fixed length verdict wrong");
    var_len_a: assert property (rx_length_valid && !fixed_length_mode |=>
        rx_length_ok_q == ($past(rx_length) <= $past(frame_cfg_q.packet_length)))
        else $error("variable length verdict wrong");
    len_hold_a: assert property (!rx_length_valid |=> $stable(rx_length_ok_q))
        else $error("length verdict moved without a check");
    // Config may only move with a completed write, never on its own
    cfg_write_a: assert property ($past(aresetn) &&
        $changed({frame_cfg_q, pin_drive_strength_q}) |-> $rose(s_axi_bvalid))
        else $error("config changed outside a write");
    write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    read_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    cover property (rx_length_valid && fixed_length_mode && rx_length_ok_q);
    cover property (rx_length_valid && !fixed_length_mode);
    cover property ($rose(s_axi_bvalid) && pin_drive_strength_q);
endmodule
bind rdc_regs rdc_regs_chk i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rdata,
    .fixed_length_mode, .rx_length_valid, .rx_length, .frame_cfg_q, .rx_length_ok_q,
    .pin_drive_strength_q, .port_one_pin_seven_q, .port_one_pin_six_q, .port_one_pin_five_q);
`default_nettype wire

// ===== verif/rdc_regs_bench.sv
/* Self-checking bench for rdc_regs: AXI4-Lite register access, pin routing,
   length verdicts. Assumes the checker file is compiled alongside. */
`include "rdc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("MISMATCH t=%0t %s got %0h exp %0h", $time, msg, got, exp); end end
module rdc_regs_bench;
    logic                    aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic                    s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic                    s_axi_bvalid, s_axi_arready, s_axi_rvalid, fixed_length_mode;
    logic                    rx_length_valid, rx_length_ok_q, pin_drive_strength_q;
    logic                    port_one_pin_seven_q, port_one_pin_six_q, port_one_pin_five_q;
    logic [`RDC_ADDR_W-1:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0]             s_axi_wdata, s_axi_rdata;
    logic [3:0]              s_axi_wstrb;
    logic [1:0]              s_axi_bresp, s_axi_rresp;
    logic [63:0]             radio_signals;
    logic [7:0]              rx_length, d, shadow [6];
    rdc_pkg::rdc_frame_cfg_s frame_cfg_q;
    int                      n_fail, samples_checked;
    localparam logic [`RDC_ADDR_W-1:0] ADR [6] = '{`RDC_ADDR_FRAME_HI, `RDC_ADDR_FRAME_LO,
        `RDC_ADDR_PKT_LEN, `RDC_ADDR_PIN_A, `RDC_ADDR_PIN_B, `RDC_ADDR_PIN_C};
    localparam logic [7:0] RST [6] = '{8'hd3, 8'h91, 8'hff, 8'h00, 8'h00, 8'h00};
    localparam logic [`RDC_ADDR_W-1:0] HOLE = 22'h037c0c;

    rdc_regs #(.NUM_SIG(64)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .radio_signals, .fixed_length_mode, .rx_length_valid, .rx_length, .frame_cfg_q,
        .rx_length_ok_q, .pin_drive_strength_q, .port_one_pin_seven_q, .port_one_pin_six_q,
        .port_one_pin_five_q);

    // Unused bit 7 of pin A and pin C never holds a written one
    function automatic logic [7:0] exp_val(int i, logic [7:0] v);
        return (i == 3 || i == 5) ? {1'b0, v[6:0]} : v;
    endfunction

    function automatic logic len_ok(logic fx, logic [7:0] lim, logic [7:0] rx);
        return fx ? (rx == lim) : (rx <= lim);
    endfunction

    task automatic wr(input logic [`RDC_ADDR_W-1:0] a, input logic [7:0] v, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er, "bresp")
    endtask

    task automatic rd(input logic [`RDC_ADDR_W-1:0] a, input logic [7:0] ev, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rresp, er, "rresp")
        `CHK(s_axi_rdata, {24'h0, ev}, "rdata")
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // Budget well above the under one thousand cycles the tests need
    initial begin
        #2000000;
        n_fail++;
        print_verdict();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {fixed_length_mode, rx_length_valid, rx_length, radio_signals} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'h1;
        void'($urandom(32'h983f));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (RST[i]) rd(ADR[i], RST[i], `RDC_RESP_OKAY);
        `CHK(frame_cfg_q, 24'hd391ff, "frame cfg reset")
        rd(HOLE, 8'h00, `RDC_RESP_SLVERR);
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            foreach (shadow[i]) begin
                d = (k == 0) ? 8'hff : 8'($urandom);
                wr(ADR[i], d, `RDC_RESP_OKAY);
                shadow[i] = exp_val(i, d);
                rd(ADR[i], shadow[i], `RDC_RESP_OKAY);
            end
            wr(HOLE, 8'($urandom), `RDC_RESP_SLVERR);
            `CHK(frame_cfg_q, {shadow[0], shadow[1], shadow[2]}, "frame cfg")
            `CHK(pin_drive_strength_q, shadow[4][7], "drive")
        end
        // A write with byte lane 0 masked completes but must leave the register alone
        s_axi_wstrb <= 4'he;
        wr(ADR[0], ~shadow[0], `RDC_RESP_OKAY);
        s_axi_wstrb <= 4'h1;
        rd(ADR[0], shadow[0], `RDC_RESP_OKAY);
        `CHK(frame_cfg_q, {shadow[0], shadow[1], shadow[2]}, "masked write")
        $display("test register access done");
        for (int k = 0; k < 24; k++) begin
            for (int i = 3; i < 6; i++) begin
                d = (k == 0) ? 8'h7f : 8'($urandom);
                wr(ADR[i], d, `RDC_RESP_OKAY);
                shadow[i] = exp_val(i, d);
            end
            radio_signals <= {$urandom, $urandom};
            repeat (2) @(posedge aclk);
            #1;
            `CHK(port_one_pin_seven_q, radio_signals[shadow[3][5:0]] ^ shadow[3][6], "a")
            `CHK(port_one_pin_six_q, radio_signals[shadow[4][5:0]] ^ shadow[4][6], "b")
            `CHK(port_one_pin_five_q, radio_signals[shadow[5][5:0]] ^ shadow[5][6], "c")
        end
        $display("test pin routing done");
        for (int m = 0; m < 2; m++) begin
            d = 8'($urandom);
            wr(ADR[2], d, `RDC_RESP_OKAY);
            fixed_length_mode <= m[0];
            for (int k = 0; k < 24; k++) begin
                @(posedge aclk);
                rx_length_valid <= 1'b1;
                rx_length <= (k == 0) ? d : (k == 1) ? d + 8'h1 : (k == 2) ? d - 8'h1 : 8'($urandom);
                @(posedge aclk);
                rx_length_valid <= 1'b0;
                #1;
                `CHK(rx_length_ok_q, len_ok(m[0], d, rx_length), "length verdict")
            end
        end
        $display("test length check done");
        // Reset again in mid-run, after every register holds a written value
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (RST[i]) rd(ADR[i], RST[i], `RDC_RESP_OKAY);
        `CHK(frame_cfg_q, 24'hd391ff, "frame cfg mid reset")
        `CHK(pin_drive_strength_q, 1'b0, "drive mid reset")
        `CHK(rx_length_ok_q, 1'b0, "length verdict mid reset")
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
